/* protect_map.vh */
`ifndef PROTECT_MAP_VH
`define PROTECT_MAP_VH

// ==========================================================
// protection_status field positions and reset value
`define PS_PIN_EN_BIT      7
`define PS_RSVD_HI_BIT     6
`define PS_TOP_BOT_BIT     5
`define PS_BPS_MSB         4
`define PS_BPS_LSB         2
`define PS_WEL_BIT         1
`define PS_RSVD_LO_BIT     0
`define PS_RESET           8'h00

// ==========================================================
// command codes
`define CMD_WRITE_ENABLE   8'h06
`define CMD_WRITE_DISABLE  8'h04
`define CMD_READ_STATUS    8'h05
`define CMD_WRITE_STATUS   8'h01
`define CMD_WRITE_ARRAY    8'h02

// ==========================================================
// density codes and addressable bits
`define DENSITY_1MB        2'h0
`define DENSITY_4MB        2'h1
`define DENSITY_8MB        2'h2
`define DENSITY_16MB       2'h3
`define ADDR_BITS_1MB      17
`define ADDR_BITS_4MB      19
`define ADDR_BITS_8MB      20
`define ADDR_BITS_16MB     21

// ==========================================================
// index of the last bit of each frame field, in link clock bits
`define CMD_LAST_BIT       5'h07
`define ADDR_LAST_BIT      5'h17
`define BYTE_LAST_BIT      3'h7

`endif

/* block_protect_check.v */
`timescale 1ns/1ps
`include "protect_map.vh"

module block_protect_check #(
  parameter ADDR_BITS = `ADDR_BITS_16MB
) (
  input  wire [23:0] address,
  input  wire        top_bottom_select,
  input  wire [2:0]  block_protect_select,
  output reg         in_protected
);

  // ==========================================================
  // region mask
  // the protected region is the top k address bits all set (top) or
  // all clear (bottom); k = 7 - select, so select 7 masks nothing
  // and both tests pass: the whole array
  reg [23:0] mask;
  integer    i;
  integer    k;

  always @* begin
    k = 7 - block_protect_select;
    for (i = 0; i < 24; i = i + 1) begin
      mask[i] = (i < ADDR_BITS) && (i >= ADDR_BITS - k);
    end
    if (block_protect_select == 3'h0) begin
      in_protected = 1'b0;
    end else if (top_bottom_select) begin
      in_protected = ((address & mask) == 24'h000000);
    end else begin
      in_protected = ((address & mask) == mask);
    end
  end

endmodule

/* serial_mram_write_protect.v */
`timescale 1ns/1ps
`include "protect_map.vh"

module serial_mram_write_protect #(
  parameter [1:0] DENSITY = `DENSITY_16MB
) (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        spi_clk,
  input  wire        chip_select_n,
  input  wire        serial_in,
  input  wire        write_protect_n,
  output reg         serial_out,
  output reg         serial_out_oe,
  output reg         mem_write,
  output reg  [23:0] mem_addr,
  output reg  [7:0]  mem_wdata,
  output reg         write_rejected,
  output wire [7:0]  protection_status,
  output reg         write_enable_latch
);

  // ==========================================================
  // density decode
  function integer density_bits;
    input [1:0] code;
    begin
      case (code)
        `DENSITY_1MB: density_bits = `ADDR_BITS_1MB;
        `DENSITY_4MB: density_bits = `ADDR_BITS_4MB;
        `DENSITY_8MB: density_bits = `ADDR_BITS_8MB;
        default:      density_bits = `ADDR_BITS_16MB;
      endcase
    end
  endfunction

  function [23:0] low_mask;
    input integer bits;
    integer j;
    begin
      for (j = 0; j < 24; j = j + 1) begin
        low_mask[j] = (j < bits);
      end
    end
  endfunction

  localparam integer    ADDR_BITS = density_bits(DENSITY);
  localparam [23:0]     ADDR_MASK = low_mask(ADDR_BITS);

  // upper bits forced low, so an address beyond the array aliases back onto it
  function [23:0] wrap_addr;
    input [23:0] a;
    begin
      wrap_addr = a & ADDR_MASK;
    end
  endfunction

  // a write goes ahead only with the latch set and nothing blocking it
  function write_gate;
    input latch;
    input blocked;
    begin
      write_gate = latch & ~blocked;
    end
  endfunction

  localparam [1:0] ST_CMD    = 2'h0;
  localparam [1:0] ST_ADDR   = 2'h1;
  localparam [1:0] ST_DATA   = 2'h2;
  localparam [1:0] ST_IGNORE = 2'h3;

  // ==========================================================
  // pin synchronisers
  // the link clock is only oversampled; at 50 MHz against a slower
  // link this leaves several cycles between edges
  reg sclk_meta;
  reg sclk_sync;
  reg sclk_last;
  reg cs_meta;
  reg cs_sync;
  reg cs_last;
  reg si_meta;
  reg si_sync;
  reg wp_meta;
  reg wp_sync;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      // idle pin levels, so no false edge follows reset
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_last <= 1'b0;
      cs_meta   <= 1'b1;
      cs_sync   <= 1'b1;
      cs_last   <= 1'b1;
      si_meta   <= 1'b0;
      si_sync   <= 1'b0;
      wp_meta   <= 1'b1;
      wp_sync   <= 1'b1;
    end else begin
      sclk_meta <= spi_clk;
      sclk_sync <= sclk_meta;
      sclk_last <= sclk_sync;
      cs_meta   <= chip_select_n;
      cs_sync   <= cs_meta;
      cs_last   <= cs_sync;
      si_meta   <= serial_in;
      si_sync   <= si_meta;
      wp_meta   <= write_protect_n;
      wp_sync   <= wp_meta;
    end
  end

  wire sclk_rise = sclk_sync & ~sclk_last;
  wire sclk_fall = ~sclk_sync & sclk_last;
  wire cs_end    = cs_sync & ~cs_last;
  wire selected  = ~cs_sync;

  // ==========================================================
  // protection_status fields
  reg       pin_protect_enable;
  reg       top_bottom_select;
  reg [2:0] block_protect_select;

  assign protection_status = {pin_protect_enable, 1'b0, top_bottom_select,
                              block_protect_select, write_enable_latch,
                              1'b0};

  // ==========================================================
  // frame state
  reg [1:0]  phase;
  reg [4:0]  bit_cnt;
  reg [2:0]  byte_bit;
  reg [7:0]  cmd;
  reg        cmd_valid;
  reg [23:0] addr_shift;
  reg [23:0] addr;
  reg [7:0]  data_shift;
  reg [7:0]  read_shift;
  reg        reading;

  wire [7:0]  next_cmd    = {addr_shift[6:0], si_sync};
  wire [23:0] next_addr   = {addr_shift[22:0], si_sync};
  wire [7:0]  next_byte   = {data_shift[6:0], si_sync};
  wire [23:0] decoded     = wrap_addr(addr);
  wire        in_protected;

  // a low pin only matters once the enable bit is set
  wire pin_gated       = pin_protect_enable & ~wp_sync;
  // status write permitted only with the latch set and the pin not gating
  wire status_write_ok = write_gate(write_enable_latch, pin_gated);
  // array write permitted only with the latch set and outside the region
  wire array_write_ok  = write_gate(write_enable_latch, in_protected);

  block_protect_check #(
    .ADDR_BITS (ADDR_BITS)
  ) u_check (
    .address              (decoded),
    .top_bottom_select    (top_bottom_select),
    .block_protect_select (block_protect_select),
    .in_protected         (in_protected)
  );

  // ==========================================================
  // command, address and data capture
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase                <= ST_CMD;
      bit_cnt              <= 5'h00;
      byte_bit             <= 3'h0;
      cmd                  <= 8'h00;
      cmd_valid            <= 1'b0;
      addr_shift           <= 24'h000000;
      addr                 <= 24'h000000;
      data_shift           <= 8'h00;
      reading              <= 1'b0;
      mem_write            <= 1'b0;
      mem_addr             <= 24'h000000;
      mem_wdata            <= 8'h00;
      write_rejected       <= 1'b0;
      pin_protect_enable   <= 1'b0;
      top_bottom_select    <= 1'b0;
      block_protect_select <= 3'h0;
      write_enable_latch   <= 1'b0;
    end else begin
      mem_write      <= 1'b0;
      write_rejected <= 1'b0;
      if (!selected) begin
        phase    <= ST_CMD;
        bit_cnt  <= 5'h00;
        byte_bit <= 3'h0;
        reading  <= 1'b0;
        if (cs_end && cmd_valid) begin
          case (cmd)
            `CMD_WRITE_ENABLE:  write_enable_latch <= 1'b1;
            `CMD_WRITE_DISABLE: write_enable_latch <= 1'b0;
            `CMD_WRITE_STATUS:  write_enable_latch <= 1'b0;
            `CMD_WRITE_ARRAY:   write_enable_latch <= 1'b0;
            default:            write_enable_latch <= write_enable_latch;
          endcase
        end
        if (cs_end) begin
          cmd_valid <= 1'b0;
        end
      end else if (sclk_rise) begin
        case (phase)
          ST_CMD: begin
            addr_shift <= next_addr;
            bit_cnt    <= bit_cnt + 5'h01;
            if (bit_cnt == `CMD_LAST_BIT) begin
              cmd       <= next_cmd;
              cmd_valid <= 1'b1;
              bit_cnt   <= 5'h00;
              case (next_cmd)
                `CMD_WRITE_STATUS: phase <= ST_DATA;
                `CMD_WRITE_ARRAY:  phase <= ST_ADDR;
                `CMD_READ_STATUS: begin
                  phase   <= ST_IGNORE;
                  reading <= 1'b1;
                end
                default:           phase <= ST_IGNORE;
              endcase
            end
          end
          ST_ADDR: begin
            addr_shift <= next_addr;
            bit_cnt    <= bit_cnt + 5'h01;
            if (bit_cnt == `ADDR_LAST_BIT) begin
              addr  <= next_addr;
              phase <= ST_DATA;
            end
          end
          ST_DATA: begin
            data_shift <= next_byte;
            byte_bit   <= byte_bit + 3'h1;
            if (byte_bit == `BYTE_LAST_BIT) begin
              if (cmd == `CMD_WRITE_STATUS) begin
                phase <= ST_IGNORE;
                if (status_write_ok) begin
                  pin_protect_enable   <= next_byte[`PS_PIN_EN_BIT];
                  top_bottom_select    <= next_byte[`PS_TOP_BOT_BIT];
                  block_protect_select <= next_byte[`PS_BPS_MSB:`PS_BPS_LSB];
                end else begin
                  write_rejected <= 1'b1;
                end
              end else begin
                if (array_write_ok) begin
                  mem_write <= 1'b1;
                  mem_addr  <= decoded;
                  mem_wdata <= next_byte;
                end else begin
                  write_rejected <= 1'b1;
                end
                // discarded bytes still move the address on
                addr <= wrap_addr(addr + 24'h000001);
              end
            end
          end
          default: begin
            phase <= ST_IGNORE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // status read-out on falling link edges
  // the status byte repeats for as long as the host keeps clocking
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      read_shift    <= 8'h00;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (!selected || !reading) begin
      read_shift    <= protection_status;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (sclk_fall) begin
      serial_out    <= read_shift[7];
      serial_out_oe <= 1'b1;
      read_shift    <= {read_shift[6:0], read_shift[7]};
    end
  end

endmodule

/* serial_mram_write_protect_properties.sv */
`timescale 1ns/1ps
module serial_mram_write_protect_properties #(
  parameter [1:0] DENSITY = 2'h3
) (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        chip_select_n,
  input wire logic        write_protect_n,
  input wire logic        serial_out_oe,
  input wire logic        mem_write,
  input wire logic [23:0] mem_addr,
  input wire logic        write_rejected,
  input wire logic [7:0]  protection_status,
  input wire logic        write_enable_latch
);
  localparam int AB = (DENSITY == 2'h0) ? 17 : 18 + DENSITY;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ==========
  // status register
  property p_init;
    $rose(resetn) |-> protection_status == 8'h00;
  endproperty
  a_init: assert property (p_init) else $error("status not default");
  property p_rsvd;
    protection_status[6] == 1'b0 && protection_status[0] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_latch_bit;
    protection_status[1] == write_enable_latch;
  endproperty
  a_latch_bit: assert property (p_latch_bit) else $error("bit 1 not latch");
  // pin passes two sync flops, so the gating level is three samples back
  property p_ps_guard;
    $changed(protection_status[7:2]) |-> $past(write_enable_latch) &&
      ($past(write_protect_n, 3) || !$past(protection_status[7]));
  endproperty
  a_ps_guard: assert property (p_ps_guard) else $error("status write unguarded");
  property p_latch_cs;
    $changed(write_enable_latch) |-> chip_select_n;
  endproperty
  a_latch_cs: assert property (p_latch_cs) else $error("latch moved in frame");
  // ==========
  // array writes
  property p_wr_latch;
    mem_write |-> write_enable_latch;
  endproperty
  a_wr_latch: assert property (p_wr_latch) else $error("write without latch");
  property p_wr_pulse;
    mem_write |=> !mem_write [*8];
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  property p_addr_hi;
    mem_write |-> (mem_addr >> AB) == 24'h000000;
  endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("upper address bits set");
  property p_all_prot;
    mem_write |-> protection_status[4:2] != 3'h7;
  endproperty
  a_all_prot: assert property (p_all_prot) else $error("write in full protection");
  c_wr: cover property (mem_write);
  c_rej: cover property (write_rejected);
  c_oe: cover property (serial_out_oe);
endmodule

bind serial_mram_write_protect serial_mram_write_protect_properties #(
  .DENSITY(DENSITY)
) chk_u (
  .ref_clk           (ref_clk),
  .resetn            (resetn),
  .chip_select_n     (chip_select_n),
  .write_protect_n   (write_protect_n),
  .serial_out_oe     (serial_out_oe),
  .mem_write         (mem_write),
  .mem_addr          (mem_addr),
  .write_rejected    (write_rejected),
  .protection_status (protection_status),
  .write_enable_latch(write_enable_latch)
);

/* spi_host.sv */
`timescale 1ns/1ps
module spi_host (
  input  wire logic ref_clk,
  input  wire logic serial_out,
  output logic      spi_clk,
  output logic      chip_select_n,
  output logic      serial_in
);
  initial begin
    spi_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // ==========
  // frames: 80 ns half period, clock rests low between frames
  task start;
    chip_select_n = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  task xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      repeat (4) @(negedge ref_clk);
      spi_clk = 1'b1;
      repeat (4) @(negedge ref_clk);
      rx[i] = serial_out;
      spi_clk = 1'b0;
    end
  endtask
  task stop;
    repeat (4) @(negedge ref_clk);
    chip_select_n = 1'b1;
    serial_in = ~serial_in; // released line shows no stale bit
    repeat (12) @(negedge ref_clk);
  endtask
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
`include "protect_map.vh"
module tb_top;
  localparam [23:0] SZ = 24'h020000;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        write_protect_n = 1'b1;
  wire         spi_clk, chip_select_n, serial_in, serial_out, serial_out_oe;
  wire         mem_write, write_rejected, write_enable_latch;
  wire  [23:0] mem_addr;
  wire  [7:0]  mem_wdata, protection_status;
  wire         so_line;
  // released line shows the inverse, so a missing enable is seen
  assign so_line = serial_out_oe ? serial_out : ~serial_out;
  logic [23:0] last_addr;
  logic [7:0]  last_data, rx;
  logic [7:0]  fq[$];
  int          err_count = 0, tests_run = 0, n_wr = 0, n_rej = 0;
  always #10 ref_clk = ~ref_clk;
  serial_mram_write_protect #(.DENSITY(`DENSITY_1MB)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .spi_clk(spi_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in),
    .write_protect_n(write_protect_n), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .write_rejected(write_rejected),
    .protection_status(protection_status), .write_enable_latch(write_enable_latch));
  spi_host host_u (.ref_clk(ref_clk), .serial_out(so_line), .spi_clk(spi_clk),
    .chip_select_n(chip_select_n), .serial_in(serial_in));
  always @(negedge ref_clk) begin
    if (mem_write === 1'b1) begin
      n_wr++;
      last_addr = mem_addr;
      last_data = mem_wdata;
    end
    if (write_rejected === 1'b1)
      n_rej++;
  end
  // ==========
  // tasks
  task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task send;
    host_u.start();
    foreach (fq[i]) host_u.xbyte(fq[i], rx);
    host_u.stop();
  endtask
  task wen;
    fq = '{`CMD_WRITE_ENABLE};
    send();
  endtask
  task wrsr(input logic [7:0] v);
    fq = '{`CMD_WRITE_STATUS, v};
    send();
  endtask
  function automatic bit prot(input logic [23:0] a, input bit bt, input logic [2:0] k);
    logic [23:0] s;
    s = (k == 3'h0) ? 24'h0 : SZ >> (7 - k);
    return bt ? (a < s) : (a >= SZ - s);
  endfunction
  task print_verdict;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_count++;
    print_verdict();
  end
  // ==========
  // tests
  initial begin
    logic [2:0]  k;
    logic        bt;
    logic [23:0] a, s;
    int          w0, r0;
    bit          e0, e1;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("status", 8'h00, protection_status);
    wrsr(8'hFF);
    chk("refused", 1, n_rej);
    chk("status", 8'h00, protection_status);
    wen();
    chk("latch", 1, write_enable_latch);
    fq = '{`CMD_READ_STATUS, 8'h00};
    send();
    chk("read", 8'h02, rx);
    chk("oe", 0, serial_out_oe);
    fq = '{`CMD_WRITE_DISABLE};
    send();
    chk("latch", 0, write_enable_latch);
    write_protect_n = 1'b0;
    wen();
    wrsr(8'hFF);
    chk("status", 8'hBC, protection_status);
    wen();
    wrsr(8'h00);
    chk("status", 8'hBC, protection_status);
    write_protect_n = 1'b1;
    wen();
    wrsr(8'h00);
    chk("status", 8'h00, protection_status);
    // two bytes straddle each boundary; k=0 and k=7 wrap the address
    for (int t = 0; t < 16; t++) begin
      k = t[2:0];
      bt = t[3];
      wen();
      wrsr({2'b00, bt, k, 2'b00});
      chk("status", {2'b00, bt, k, 2'b00}, protection_status);
      s = (k == 3'h0) ? 24'h0 : SZ >> (7 - k);
      a = (bt ? s - 1 : SZ - s - 1) & (SZ - 1);
      e0 = prot(a, bt, k);
      e1 = prot((a + 1) & (SZ - 1), bt, k);
      w0 = n_wr;
      r0 = n_rej;
      wen();
      fq = '{`CMD_WRITE_ARRAY, a[23:16], a[15:8], a[7:0], 8'hC3, 8'h3C};
      send();
      chk("writes", w0 + !e0 + !e1, n_wr);
      chk("refused", r0 + e0 + e1, n_rej);
      if (!e1) begin
        chk("addr", (a + 1) & (SZ - 1), last_addr);
        chk("data", 8'h3C, last_data);
      end
      chk("latch", 0, write_enable_latch);
    end
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("status", 8'h00, protection_status);
    print_verdict();
  end
endmodule
